// ===== skm_pkg.sv
// shared widths, modes and reset values for the shift keying control block
`default_nettype none
package skm_pkg;

    localparam int unsigned FREQ_W   = 32;
    localparam int unsigned PHASE_W  = 16;
    localparam int unsigned RATE_W   = 32;
    localparam int unsigned SYM_W    = 2;
    localparam int unsigned LFSR_W   = 16;
    localparam int unsigned SYNC_STAGES = 3;

    localparam logic [SYM_W-1:0]   SYM_CARRIER = 2'h0;
    localparam logic [SYM_W-1:0]   SYM_HOP1    = 2'h1;
    localparam logic [SYM_W-1:0]   SYM_HOP2    = 2'h2;
    localparam logic [SYM_W-1:0]   SYM_HOP3    = 2'h3;

    localparam logic [RATE_W-1:0]  CNT_RESET   = 32'h0000_0000;
    localparam logic [LFSR_W-1:0]  LFSR_SEED   = 16'hACE1;
    // feedback taps for x^16 + x^14 + x^13 + x^11 + 1
    localparam logic [LFSR_W-1:0]  LFSR_TAPS   = 16'hB400;

    typedef enum logic [2:0] {
        SKM_TWO_LEVEL_FREQ,
        SKM_FOUR_SEQ_FREQ,
        SKM_FOUR_RND_FREQ,
        SKM_TWO_LEVEL_PHASE,
        SKM_FOUR_SEQ_PHASE,
        SKM_FOUR_RND_PHASE
    } skm_mode_t;

endpackage : skm_pkg
`default_nettype wire

// ===== skm_sync3.sv
// three-stage synchroniser that accepts a new level once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module skm_sync3
(
    input  wire logic sys_clk,   // system clock
    input  wire logic reset,     // synchronous reset, active high
    input  wire logic async_in,  // pin level from outside the clock domain
    output logic      level_q    // filtered, synchronised level
);

    logic stage1_q;
    logic stage2_q;
    logic stage3_q;
    wire  agree = (stage2_q == stage3_q);

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
            stage3_q <= 1'b0;
            level_q  <= 1'b0;
        end
        else
        begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            // stage1 feeds only stage2, so a metastable value never reaches the compare
            if (agree)
                level_q <= stage3_q;
        end
    end

endmodule : skm_sync3
`default_nettype wire

// ===== skm_keying_ctrl.sv
// symbol selection and sync generation for frequency and phase shift keying
// How it works
// R1 - two-level freq: carrier and hop alternate
// R2 - four-level sequential freq: carrier, hop1, hop2, hop3
// R3 - four-level random freq: random pick each step
// R4 - internal steps at rate; external steps on trigger
// R5 - hops are absolute values, not carrier offsets
// R6 - only one channel may own external triggers
// R7 - source drives high bit on other channel
// R8 - two-level freq external: level picks, polarity inverts
// R9 - external sequential freq: two bits pick symbol
// R10 - random modes: trigger only causes a step
// R11 - internal freq sync: 50% duty at rate
// R12 - two-level freq sync: low carrier, high hop
// R13 - sequential freq sync high on hop1, hop3
// R14 - random modes: sync unrelated to symbol
// R15 - external source: sync follows trigger line
// R16 - two-level phase: carrier and hop alternate
// R17 - four-level sequential phase cycles in order
// R18 - four-level random phase: random pick each step
// R19 - two-level phase external: level picks, polarity inverts
// R20 - external sequential phase: two bits pick symbol
// R21 - internal phase sync 50%, low carrier, high hop
// R22 - sequential phase sync high on hop1, hop3
// R23 - internal step strobe from clock divider
// R24 - random symbols drawn from free-running shift register
`timescale 1ns/1ps
`default_nettype none
module skm_keying_ctrl
(
    input  wire logic                          sys_clk,         // system clock, 100 MHz
    input  wire logic                          reset,           // synchronous reset, active high
    input  wire skm_pkg::skm_mode_t            mode_sel,        // keying mode
    input  wire logic                          ext_source,      // 1 = external trigger steps
    input  wire logic                          polarity_neg,    // 1 = negative trigger polarity
    input  wire logic                          other_ch_ext,    // other channel owns triggers
    input  wire logic [skm_pkg::RATE_W-1:0]    rate_div,        // clocks per keying step
    input  wire logic                          trig_lo_in,      // low trigger bit, async pin
    input  wire logic                          trig_hi_in,      // high trigger bit, async pin
    input  wire logic [skm_pkg::FREQ_W-1:0]    carrier_freq,    // carrier frequency word
    input  wire logic [skm_pkg::FREQ_W-1:0]    hop_freq1,       // hop_frequency_value 1
    input  wire logic [skm_pkg::FREQ_W-1:0]    hop_freq2,       // hop_frequency_value 2
    input  wire logic [skm_pkg::FREQ_W-1:0]    hop_freq3,       // hop_frequency_value 3
    input  wire logic [skm_pkg::PHASE_W-1:0]   carrier_phase,   // carrier phase word
    input  wire logic [skm_pkg::PHASE_W-1:0]   hop_phase1,      // hop_phase_value 1
    input  wire logic [skm_pkg::PHASE_W-1:0]   hop_phase2,      // hop_phase_value 2
    input  wire logic [skm_pkg::PHASE_W-1:0]   hop_phase3,      // hop_phase_value 3
    output logic [skm_pkg::FREQ_W-1:0]         freq_word_q,     // frequency word to oscillator
    output logic [skm_pkg::PHASE_W-1:0]        phase_word_q,    // phase word to oscillator
    output logic [skm_pkg::SYM_W-1:0]          symbol_q,        // selected symbol index
    output logic                               step_q,          // one-cycle pulse per step
    output logic                               sync_q,          // sync output level
    output logic                               ext_active_q     // external triggers in use
);

    // synchronised trigger lines
    logic trig_lo_s;
    logic trig_hi_s;

    skm_sync3 u_sync_lo
    (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in (trig_lo_in),
        .level_q  (trig_lo_s)
    );

    skm_sync3 u_sync_hi
    (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in (trig_hi_in),
        .level_q  (trig_hi_s)
    );

    logic [skm_pkg::RATE_W-1:0] cnt_q;
    logic [skm_pkg::RATE_W-1:0] cnt_d;
    logic [skm_pkg::LFSR_W-1:0] lfsr_q;
    logic [skm_pkg::LFSR_W-1:0] lfsr_d;
    logic                       ext_lev_q;
    logic                       rnd_sync_q;
    logic [skm_pkg::SYM_W-1:0]  symbol_d;
    logic                       sync_d;

    // mode decode
    wire mode_two  = (mode_sel == skm_pkg::SKM_TWO_LEVEL_FREQ)
                   || (mode_sel == skm_pkg::SKM_TWO_LEVEL_PHASE);
    wire mode_seq  = (mode_sel == skm_pkg::SKM_FOUR_SEQ_FREQ)
                   || (mode_sel == skm_pkg::SKM_FOUR_SEQ_PHASE);
    wire mode_rnd  = (mode_sel == skm_pkg::SKM_FOUR_RND_FREQ)
                   || (mode_sel == skm_pkg::SKM_FOUR_RND_PHASE);
    wire mode_freq = (mode_sel == skm_pkg::SKM_TWO_LEVEL_FREQ)
                   || (mode_sel == skm_pkg::SKM_FOUR_SEQ_FREQ)
                   || (mode_sel == skm_pkg::SKM_FOUR_RND_FREQ);

    // R6 shared triggers
    // a request is refused while the other channel owns the trigger pins
    wire ext_on = ext_source && !other_ch_ext;

    // R23 internal rate divider
    // a divide value of zero behaves as one so the strobe never stalls
    wire [skm_pkg::RATE_W-1:0] div_last = (rate_div == skm_pkg::CNT_RESET)
                                        ? skm_pkg::CNT_RESET
                                        : rate_div - 32'h0000_0001;
    wire int_step = !ext_on && (cnt_q >= div_last);
    assign cnt_d  = (ext_on || int_step) ? skm_pkg::CNT_RESET : cnt_q + 32'h0000_0001;

    // R8 R19 polarity applies to the level seen in external mode
    wire ext_lev  = trig_lo_s ^ polarity_neg;
    // R10 random modes step on the active edge only
    wire ext_edge = ext_on && ext_lev && !ext_lev_q;

    // R4 step source
    wire step_now = ext_on ? (mode_rnd ? ext_edge : 1'b0) : int_step;

    // R24 free-running sequence
    wire lfsr_fb = ^(lfsr_q & skm_pkg::LFSR_TAPS);
    assign lfsr_d = {lfsr_q[skm_pkg::LFSR_W-2:0], lfsr_fb};

    // symbol selection by mode and source
    wire [skm_pkg::SYM_W-1:0] sym_two_int = {1'b0, ~symbol_q[0]};
    wire [skm_pkg::SYM_W-1:0] sym_seq_int = symbol_q + 2'h1;
    wire [skm_pkg::SYM_W-1:0] sym_two_ext = {1'b0, ext_lev};
    wire [skm_pkg::SYM_W-1:0] sym_seq_ext = {trig_hi_s, trig_lo_s};
    wire [skm_pkg::SYM_W-1:0] sym_rnd     = lfsr_q[skm_pkg::SYM_W-1:0];

    always_comb
    begin
        symbol_d = symbol_q;
        if (mode_two)
        begin
            // R1 R16 alternate; R8 R19 external level picks
            if (ext_on)
                symbol_d = sym_two_ext;
            else if (step_now)
                symbol_d = sym_two_int;
        end
        else if (mode_seq)
        begin
            // R2 R17 fixed order; R9 R20 external bits pick, polarity ignored
            if (ext_on)
                symbol_d = sym_seq_ext;
            else if (step_now)
                symbol_d = sym_seq_int;
        end
        else if (mode_rnd && step_now)
        begin
            // R3 R18 random pick at each step
            symbol_d = sym_rnd;
        end
    end

    // two-level sync makes one full cycle per carrier and hop pair
    // R11 R21 internal sync: 50% duty; R12 R13 R21 R22 low on carrier and hop2
    // R14 random modes toggle per step, unrelated to the chosen symbol
    // R15 external source: sync follows the received trigger line
    wire sync_int = mode_rnd ? (rnd_sync_q ^ step_now) : symbol_d[0];
    assign sync_d = ext_on ? trig_lo_s : sync_int;

    // R5 hop values are absolute words, muxed straight through
    wire [skm_pkg::FREQ_W-1:0] freq_pick =
        (symbol_d == skm_pkg::SYM_HOP1) ? hop_freq1 :
        (symbol_d == skm_pkg::SYM_HOP2) ? hop_freq2 :
        (symbol_d == skm_pkg::SYM_HOP3) ? hop_freq3 : carrier_freq;
    wire [skm_pkg::PHASE_W-1:0] phase_pick =
        (symbol_d == skm_pkg::SYM_HOP1) ? hop_phase1 :
        (symbol_d == skm_pkg::SYM_HOP2) ? hop_phase2 :
        (symbol_d == skm_pkg::SYM_HOP3) ? hop_phase3 : carrier_phase;
    wire [skm_pkg::FREQ_W-1:0]  freq_d  = mode_freq ? freq_pick : carrier_freq;
    wire [skm_pkg::PHASE_W-1:0] phase_d = mode_freq ? carrier_phase : phase_pick;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            cnt_q        <= skm_pkg::CNT_RESET;
            lfsr_q       <= skm_pkg::LFSR_SEED;
            // edge history starts at the level ext_lev has while trig_lo_s is reset low, so release gives no false step
            ext_lev_q    <= polarity_neg;
            rnd_sync_q   <= 1'b0;
            symbol_q     <= skm_pkg::SYM_CARRIER;
            step_q       <= 1'b0;
            sync_q       <= 1'b0;
            ext_active_q <= 1'b0;
            freq_word_q  <= '0;
            phase_word_q <= '0;
        end
        else
        begin
            cnt_q        <= cnt_d;
            lfsr_q       <= lfsr_d;
            ext_lev_q    <= ext_lev;
            rnd_sync_q   <= sync_int;
            symbol_q     <= symbol_d;
            step_q       <= step_now;
            sync_q       <= sync_d;
            ext_active_q <= ext_on;
            freq_word_q  <= freq_d;
            phase_word_q <= phase_d;
        end
    end

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // R1 two-level alternation
    a_two_level_alt: assert property ( // R1
        (mode_two && !ext_on && step_now) ##1 $stable(mode_sel)
        |-> symbol_q == {1'b0, ~$past(symbol_q[0])})
        else $error("two-level symbol did not alternate");

    // R2 sequential order
    a_seq_order: assert property ( // R2
        (mode_seq && !ext_on && step_now) |=> symbol_q == $past(symbol_q) + 2'h1)
        else $error("sequential symbol out of order");

    // R3 random pick source
    a_rnd_pick: assert property ( // R3
        (mode_rnd && step_now) |=> symbol_q == $past(lfsr_q[1:0]))
        else $error("random symbol not taken from sequence");

    // R23 divider period
    a_div_period: assert property ( // R23
        (!ext_on && rate_div == 32'h0000_0003 && int_step) ##1 $stable(rate_div) && !ext_on
        |-> !int_step ##1 !int_step)
        else $error("internal step came early");

    // R4 no internal steps while external
    a_ext_no_rate: assert property ( // R4
        (ext_on && !mode_rnd) |=> !step_q && cnt_q == skm_pkg::CNT_RESET)
        else $error("rate step while external source active");

    // R8 external two-level map
    a_ext_two_map: assert property ( // R8
        (ext_on && mode_two) |=> symbol_q == {1'b0, $past(trig_lo_s ^ polarity_neg)})
        else $error("external two-level mapping wrong");

    // R9 external sequential map
    a_ext_seq_map: assert property ( // R9
        (ext_on && mode_seq) |=> symbol_q == {$past(trig_hi_s), $past(trig_lo_s)})
        else $error("external four-level mapping wrong");

    // R10 random symbol stands without a step
    a_rnd_hold: assert property ( // R10
        (mode_rnd && !step_now) |=> $stable(symbol_q))
        else $error("random symbol changed without a step");

    // R12 sync tracks symbol in ordered modes
    a_sync_symbol: assert property ( // R12
        (!ext_on && (mode_two || mode_seq)) |=> sync_q == symbol_q[0])
        else $error("sync level does not match symbol");

    // R15 external sync from trigger
    a_ext_sync: assert property ( // R15
        ext_on |=> sync_q == $past(trig_lo_s))
        else $error("external sync not following trigger");

    // R5 frequency word follows the selected hop
    a_freq_select: assert property ( // R5
        (mode_freq && symbol_d == skm_pkg::SYM_HOP3) |=> freq_word_q == $past(hop_freq3))
        else $error("frequency word not the selected hop");

    // R6 refused while the other channel owns triggers
    a_ext_refused: assert property ( // R6
        other_ch_ext |=> !ext_active_q)
        else $error("external granted while other channel owns triggers");

    // R13 sequential freq sync
    a_seq_sync_hops: assert property ( // R13
        (!ext_on && mode_seq && mode_freq)
        |=> sync_q == (symbol_q == skm_pkg::SYM_HOP1 || symbol_q == skm_pkg::SYM_HOP3))
        else $error("sequential freq sync wrong for symbol");

    // R22 sequential phase sync
    a_seq_phase_sync: assert property ( // R22
        (!ext_on && mode_seq && !mode_freq)
        |=> sync_q == (symbol_q == skm_pkg::SYM_HOP1 || symbol_q == skm_pkg::SYM_HOP3))
        else $error("sequential phase sync wrong for symbol");

    // R14 random sync toggles per step
    a_rnd_sync_toggle: assert property ( // R14
        (mode_rnd && !ext_on && $past(!ext_on))
        |=> sync_q == ($past(sync_q) ^ $past(step_now)))
        else $error("random-mode sync did not toggle with the step");

    // R10 level alone gives no step
    a_level_no_step: assert property ( // R10
        (mode_rnd && ext_on && $stable(trig_lo_s) && $stable(polarity_neg)) |=> !step_q)
        else $error("random step without a trigger edge");

    // R17 phase word follows the selected hop
    a_phase_select: assert property ( // R17
        (!mode_freq && symbol_d == skm_pkg::SYM_HOP2) |=> phase_word_q == $past(hop_phase2))
        else $error("phase word not the selected hop");

    // R16 phase modes keep carrier frequency
    a_carrier_freq_hold: assert property ( // R16
        !mode_freq |=> freq_word_q == $past(carrier_freq))
        else $error("frequency word moved in a phase mode");

    // R19 external two-level phase map
    a_phase_two_map: assert property ( // R19
        (ext_on && mode_two && !mode_freq)
        |=> symbol_q == {1'b0, $past(trig_lo_s ^ polarity_neg)})
        else $error("external two-level phase mapping wrong");

    // R6 grant when pins free
    a_ext_granted: assert property ( // R6
        (ext_source && !other_ch_ext) |=> ext_active_q)
        else $error("external request not granted");

    c_seq_wrap: cover property (mode_seq && !ext_on && step_now && symbol_q == 2'h3);
    c_rnd_ext: cover property (mode_rnd && ext_edge);
    c_two_ext_neg: cover property (mode_two && ext_on && polarity_neg && trig_lo_s);
    c_rate_zero: cover property (rate_div == skm_pkg::CNT_RESET && int_step);
    c_two_phase_ext: cover property (mode_two && !mode_freq && ext_on);

endmodule : skm_keying_ctrl
`default_nettype wire

// ===== skm_trig_src.sv
// outside trigger source that drives the two shared keying pins
`timescale 1ns/1ps
`default_nettype none
module skm_trig_src
(
    input  wire logic want_lo, // commanded low trigger bit
    input  wire logic want_hi, // commanded high trigger bit
    output wire logic trig_lo, // this channel's trigger pin
    output wire logic trig_hi  // other channel's trigger pin
);
    // two lines, high bit on the other pin
    // pins move a few ns after a command, never on a clock edge
    assign #3 trig_lo = want_lo;
    assign #3 trig_hi = want_hi;
endmodule : skm_trig_src
`default_nettype wire

// ===== skm_keying_ctrl_bench.sv
// self-checking bench for the shift keying control block
`timescale 1ns/1ps
`default_nettype none
module skm_keying_ctrl_bench;
    logic               sys_clk = 1'b0;
    logic               reset = 1'b1;
    skm_pkg::skm_mode_t mode_sel = skm_pkg::SKM_TWO_LEVEL_FREQ;
    logic               ext_source = 1'b0;
    logic               polarity_neg = 1'b0;
    logic               other_ch_ext = 1'b0;
    logic [31:0]        rate_div = 32'h0000_0002;
    logic               want_lo = 1'b0;
    logic               want_hi = 1'b0;
    wire                trig_lo;
    wire                trig_hi;
    logic [31:0]        ft [4];
    logic [15:0]        pt [4];
    logic [31:0]        freq_word_q;
    logic [15:0]        phase_word_q;
    logic [1:0]         symbol_q;
    logic               step_q;
    logic               sync_q;
    logic               ext_active_q;
    int                 n_fail = 0;
    int                 checks_done = 0;
    int                 cyc = 0;
    int                 n_steps = 0;
    int unsigned        seed_v;
    logic [15:0]        lfsr_m;
    logic [15:0]        lfsr_p;
    logic [1:0]         rnd_sym;

    skm_trig_src src_u (.want_lo(want_lo), .want_hi(want_hi), .trig_lo(trig_lo),
        .trig_hi(trig_hi));
    skm_keying_ctrl dut_u (.sys_clk(sys_clk), .reset(reset), .mode_sel(mode_sel),
        .ext_source(ext_source), .polarity_neg(polarity_neg), .other_ch_ext(other_ch_ext),
        .rate_div(rate_div), .trig_lo_in(trig_lo), .trig_hi_in(trig_hi),
        .carrier_freq(ft[0]), .hop_freq1(ft[1]), .hop_freq2(ft[2]), .hop_freq3(ft[3]),
        .carrier_phase(pt[0]), .hop_phase1(pt[1]), .hop_phase2(pt[2]), .hop_phase3(pt[3]),
        .freq_word_q(freq_word_q), .phase_word_q(phase_word_q), .symbol_q(symbol_q),
        .step_q(step_q), .sync_q(sync_q), .ext_active_q(ext_active_q));

    always #5 sys_clk = ~sys_clk;

    task automatic print_verdict();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // step pulses are counted here; the ceiling cuts a hang short
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        // reference sequence for the random modes, one value per clock
        lfsr_p <= lfsr_m;
        if (reset)
            lfsr_m <= skm_pkg::LFSR_SEED;
        else
            lfsr_m <= {lfsr_m[14:0], ^(lfsr_m & skm_pkg::LFSR_TAPS)};
        if (step_q === 1'b1)
        begin
            n_steps <= n_steps + 1;
            rnd_sym <= lfsr_p[1:0];
        end
        if (cyc == 5000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : chk_w

    task automatic chk_b(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask : chk_b

    // phase modes keep the carrier frequency and the other way round
    function automatic logic [31:0] fw(input int m, input logic [1:0] s);
        return (m < 3) ? ft[s] : ft[0];
    endfunction : fw

    function automatic logic [31:0] pw(input int m, input logic [1:0] s);
        return {16'h0000, (m >= 3) ? pt[s] : pt[0]};
    endfunction : pw

    task automatic chk_words(input int m, input logic [1:0] s);
        chk_w(freq_word_q, fw(m, s));
        chk_w({16'h0000, phase_word_q}, pw(m, s));
    endtask : chk_words

    task automatic do_reset();
        reset = 1'b1;
        repeat (5) @(negedge sys_clk);
        chk_w(freq_word_q, 32'h0000_0000);
        chk_w({16'h0000, phase_word_q}, 32'h0000_0000);
        chk_b(step_q | sync_q | ext_active_q | symbol_q[1] | symbol_q[0], 1'b0);
        reset = 1'b0;
    endtask : do_reset

    task automatic run_int(input int m, input int r, input logic oc, input int n);
        logic [1:0] es;
        logic       ey;
        int         k;
        mode_sel = skm_pkg::skm_mode_t'(m);
        rate_div = 32'(r);
        ext_source = oc;
        other_ch_ext = oc;
        polarity_neg = 1'($urandom);
        do_reset();
        es = 2'h0;
        ey = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            k = 0;
            do
            begin
                @(negedge sys_clk);
                k++;
            end while (step_q !== 1'b1 && k < 64);
            if (i > 0)
                chk_w(32'(k), (r == 0) ? 32'h0000_0001 : 32'(r));
            es = (m % 3 == 0) ? es ^ 2'h1 : es + 2'h1;
            ey = ~ey;
            if (m % 3 == 2)
            begin
                es = lfsr_p[1:0];
                chk_w({30'h0, symbol_q}, {30'h0, es});
                chk_b(sync_q, ey);
            end
            else
            begin
                chk_w({30'h0, symbol_q}, {30'h0, es});
                chk_b(sync_q, es[0]);
            end
            chk_words(m, es);
            chk_b(ext_active_q, 1'b0);
        end
    endtask : run_int

    task automatic run_ext(input int m, input logic pol, input logic lo, input logic hi);
        logic [1:0] es;
        mode_sel = skm_pkg::skm_mode_t'(m);
        ext_source = 1'b1;
        other_ch_ext = 1'b0;
        polarity_neg = pol;
        want_lo = lo;
        want_hi = hi;
        repeat (8) @(negedge sys_clk);
        es = (m % 3 == 0) ? {1'b0, lo ^ pol} : {hi, lo};
        chk_w({30'h0, symbol_q}, {30'h0, es});
        chk_words(m, es);
        chk_b(sync_q, lo);
        chk_b(ext_active_q, 1'b1);
    endtask : run_ext

    task automatic run_rnd(input int m, input logic pol);
        mode_sel = skm_pkg::skm_mode_t'(m);
        polarity_neg = pol;
        rate_div = 32'h0000_0002;
        want_lo = pol;
        repeat (8) @(negedge sys_clk);
        n_steps = 0;
        repeat (3)
        begin
            want_lo = ~pol;
            want_hi = 1'($urandom);
            repeat (8) @(negedge sys_clk);
            want_lo = pol;
            repeat (8) @(negedge sys_clk);
        end
        chk_w(32'(n_steps), 32'h0000_0003);
        chk_w({30'h0, symbol_q}, {30'h0, rnd_sym});
        chk_words(m, rnd_sym);
        chk_b(sync_q, pol);
    endtask : run_rnd

    initial
    begin
        seed_v = $urandom(43);
        for (int i = 0; i < 4; i++)
        begin
            ft[i] = $urandom;
            pt[i] = 16'($urandom);
        end
        do_reset();
        for (int m = 0; m < 6; m++)
            run_int(m, 2 + $urandom % 4, 1'b0, 6);
        run_int(0, 3, 1'b1, 4);
        run_int(1, 0, 1'b0, 4);
        for (int j = 0; j < 4; j++)
            for (int c = 0; c < 8; c++)
                run_ext(j + j / 2, c[2], c[0], c[1]);
        for (int p = 0; p < 2; p++)
        begin
            run_rnd(2, p[0]);
            run_rnd(5, p[0]);
        end
        print_verdict();
    end
endmodule : skm_keying_ctrl_bench
`default_nettype wire
